// ---- logic/mpas_top.sv ----
// Three-phase PWM with converter trigger sequencing, encoder and slow timer
`timescale 1ns/100ps
// What this block does
// - Master reload fires only on every Nth reload opportunity, N = ratio.
// - Follower counters advance on the master's counting tick.
// - Followers reload to start value on each master reload.
// - After reload, trigger when master counter equals trigger compare value.
// - Converter trigger is delayed by half the dead time.
// - Six outputs: top and bottom for three phases.
// - Fault input disables all six outputs while active.
// - Outputs return at first reload opportunity after fault input goes low.
// - Counter runs from minus half modulo to half modulo minus one.
// - Dead time separates complementary top and bottom outputs.
// - Dead time set in nanoseconds, converted to clock counts.
// - Crossbar routes PWM trigger to sequencer trigger input 0.
// - Each converter runs a two-long chain, second started back to back.
// - Paired mode starts both converters from the same PWM trigger.
// - Fast-loop interrupt only after all started conversions complete.
// - 12-bit results; converters start only on sequencer triggers.
// - Encoder counts modulo; revolutions up on roll-over, down on roll-under.
// - Encoder counting direction is selectable.
// - Slow timer counts 0 to clock/(16*1000 Hz) compare value.
// - Slow timer raises enabled interrupt at each reload.
module mpas_top import mpas_pkg::*; #(
    parameter int SLOW_CMP = SLOW_CMP_DEF,
    parameter int PWM_PRESC = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Gate drive and fault
    output logic [2:0] pwm_top,
    output logic [2:0] pwm_bot,
    input wire logic fault_in,
    // Converters
    output logic [1:0] conv_start,
    output logic [1:0] conv_sel,
    input wire logic [1:0] conv_done,
    input wire logic [2*CONV_BITS-1:0] conv_data,
    // Encoder
    input wire logic enc_a,
    input wire logic enc_b,
    // Loop events
    output logic pwm_trigger_output,
    output logic fast_loop_irq,
    output logic slow_loop_irq
);
    if (SLOW_CMP < 1 || SLOW_CMP > 65535 || PWM_PRESC < 1
        || PWM_PRESC > 255) begin : g_bad_param
        $error("mpas_top: parameter out of range");
    end

    // Registers
    logic [31:0] ctrl_q;
    logic [15:0] modulo_q, trig_cmp_q, dead_ns_q, enc_mod_q;
    logic [15:0] duty_q [3];
    logic [15:0] position_q, revol_q;
    logic [CONV_BITS-1:0] result_q [2][CHAIN_LEN];
    logic fault_q;

    // AXI write path
    logic wr_go, wr_ok, rd_go;
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_go = s_axi_arvalid & ~s_axi_rvalid;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        wr_ok = 1'b1;
        if (s_axi_awaddr[7:2] > REG_ENC_MOD[7:2]
            || s_axi_awaddr[1:0] != 2'b00) begin
            wr_ok = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            modulo_q <= MODULO_RST;
            trig_cmp_q <= TRIG_RST;
            dead_ns_q <= DEAD_RST;
            enc_mod_q <= ENC_MOD_RST;
            duty_q <= '{default: 16'h0000};
        end else if (wr_go) begin
            if (s_axi_awaddr == REG_CTRL) begin
                ctrl_q <= merge(ctrl_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == REG_MODULO) begin
                modulo_q <= 16'(merge({16'h0, modulo_q}, s_axi_wdata,
                    s_axi_wstrb));
            end else if (s_axi_awaddr == REG_TRIG_CMP) begin
                trig_cmp_q <= 16'(merge({16'h0, trig_cmp_q}, s_axi_wdata,
                    s_axi_wstrb));
            end else if (s_axi_awaddr == REG_DEAD_NS) begin
                dead_ns_q <= 16'(merge({16'h0, dead_ns_q}, s_axi_wdata,
                    s_axi_wstrb));
            end else if (s_axi_awaddr == REG_ENC_MOD) begin
                enc_mod_q <= 16'(merge({16'h0, enc_mod_q}, s_axi_wdata,
                    s_axi_wstrb));
            end else if (s_axi_awaddr[7:4] == REG_DUTY0[7:4]
                && s_axi_awaddr[3:2] != 2'b11) begin
                duty_q[s_axi_awaddr[3:2]] <= 16'(merge({16'h0,
                    duty_q[s_axi_awaddr[3:2]]}, s_axi_wdata,
                    s_axi_wstrb));
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // AXI read path
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr == REG_CTRL) begin
                s_axi_rdata <= ctrl_q;
            end else if (s_axi_araddr == REG_MODULO) begin
                s_axi_rdata <= {16'h0, modulo_q};
            end else if (s_axi_araddr == REG_TRIG_CMP) begin
                s_axi_rdata <= {16'h0, trig_cmp_q};
            end else if (s_axi_araddr == REG_DEAD_NS) begin
                s_axi_rdata <= {16'h0, dead_ns_q};
            end else if (s_axi_araddr == REG_ENC_MOD) begin
                s_axi_rdata <= {16'h0, enc_mod_q};
            end else if (s_axi_araddr[7:4] == REG_DUTY0[7:4]
                && s_axi_araddr[3:2] != 2'b11) begin
                s_axi_rdata <= {16'h0, duty_q[s_axi_araddr[3:2]]};
            end else if (s_axi_araddr == REG_STATUS) begin
                s_axi_rdata <= {31'h0, fault_q};
            end else if (s_axi_araddr == REG_POSITION) begin
                s_axi_rdata <= {16'h0, position_q};
            end else if (s_axi_araddr == REG_REVOL) begin
                s_axi_rdata <= {16'h0, revol_q};
            end else if (s_axi_araddr == REG_CONV0) begin
                s_axi_rdata <= {4'h0, result_q[0][1], 4'h0,
                    result_q[0][0]};
            end else if (s_axi_araddr == REG_CONV1) begin
                s_axi_rdata <= {4'h0, result_q[1][1], 4'h0,
                    result_q[1][0]};
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Input synchronisers
    logic [1:0] fault_s, enca_s, encb_s, done0_s, done1_s;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fault_s <= 2'b00;
            enca_s <= 2'b00;
            encb_s <= 2'b00;
            done0_s <= 2'b00;
            done1_s <= 2'b00;
        end else begin
            fault_s <= {fault_s[0], fault_in};
            enca_s <= {enca_s[0], enc_a};
            encb_s <= {encb_s[0], enc_b};
            done0_s <= {done0_s[0], conv_done[0]};
            done1_s <= {done1_s[0], conv_done[1]};
        end
    end

    // Master counting tick, shared by followers
    logic [7:0] presc_q;
    logic tick;
    assign tick = ctrl_q[CTRL_PWM_EN] && presc_q == 8'(PWM_PRESC - 1);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            presc_q <= 8'h00;
        end else if (!ctrl_q[CTRL_PWM_EN] || tick) begin
            presc_q <= 8'h00;
        end else begin
            presc_q <= presc_q + 8'h01;
        end
    end

    // Counter limits
    logic signed [15:0] init_val, end_val;
    assign init_val = -$signed({1'b0, modulo_q[15:1]});
    assign end_val = $signed({1'b0, modulo_q[15:1]}) - 16'sd1;

    // Master counter and reload divider
    logic signed [15:0] cnt_q [3];
    logic [3:0] opp_q, ratio;
    logic opportunity, master_reload;
    assign ratio = ctrl_q[CTRL_RATIO_LO +: 4];
    assign opportunity = tick && cnt_q[0] == end_val;
    assign master_reload = opportunity
        && (ratio <= 4'h1 || opp_q == ratio - 4'h1);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            opp_q <= 4'h0;
        end else if (master_reload) begin
            opp_q <= 4'h0;
        end else if (opportunity) begin
            opp_q <= opp_q + 4'h1;
        end
    end

    // Dead time in clock counts, rounded up
    logic [15:0] dt_cyc, half_dt;
    assign dt_cyc = 16'((17'(dead_ns_q) + 17'(CLK_PERIOD_NS - 1))
        / 17'(CLK_PERIOD_NS));
    assign half_dt = {1'b0, dt_cyc[15:1]};

    // Three submodules: counter, compare, dead time
    logic [2:0] raw, phase_q, dt_busy;
    logic [15:0] dt_q [3];
    for (genvar i = 0; i < 3; i++) begin : g_sub
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                cnt_q[i] <= 16'sh0;
            end else if (!ctrl_q[CTRL_PWM_EN]) begin
                cnt_q[i] <= init_val;
            end else if (i != 0 && master_reload) begin
                cnt_q[i] <= init_val;
            end else if (tick) begin
                if (cnt_q[i] >= end_val) begin
                    cnt_q[i] <= init_val;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 16'sd1;
                end
            end
        end
        assign raw[i] = cnt_q[i] >= -$signed({1'b0, duty_q[i][15:1]})
            && cnt_q[i] < $signed({1'b0, duty_q[i][15:1]});
        assign dt_busy[i] = dt_q[i] != 16'h0;
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                phase_q[i] <= 1'b0;
                dt_q[i] <= 16'h0;
            end else if (raw[i] != phase_q[i]) begin
                phase_q[i] <= raw[i];
                dt_q[i] <= dt_cyc;
            end else if (dt_busy[i]) begin
                dt_q[i] <= dt_q[i] - 16'h1;
            end
        end
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                pwm_top[i] <= 1'b0;
                pwm_bot[i] <= 1'b0;
            end else begin
                pwm_top[i] <= ctrl_q[CTRL_PWM_EN] && !fault_q
                    && !fault_s[1] && !dt_busy[i] && phase_q[i];
                pwm_bot[i] <= ctrl_q[CTRL_PWM_EN] && !fault_q
                    && !fault_s[1] && !dt_busy[i] && !phase_q[i];
            end
        end
    end

    // Fault latch, cleared by reload opportunity once the input is low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fault_q <= 1'b0;
        end else if (fault_s[1]) begin
            fault_q <= 1'b1;
        end else if (opportunity) begin
            fault_q <= 1'b0;
        end
    end

    // Compare trigger with half dead-time delay
    logic armed_q, pend_q;
    logic [15:0] tdly_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
            pend_q <= 1'b0;
            tdly_q <= 16'h0;
            pwm_trigger_output <= 1'b0;
        end else begin
            pwm_trigger_output <= 1'b0;
            if (master_reload) begin
                armed_q <= 1'b1;
            end else if (armed_q && tick
                && cnt_q[0] == $signed(trig_cmp_q)) begin
                armed_q <= 1'b0;
                pend_q <= 1'b1;
                tdly_q <= half_dt;
            end
            if (pend_q) begin
                if (tdly_q == 16'h0) begin
                    pend_q <= 1'b0;
                    pwm_trigger_output <= 1'b1;
                end else begin
                    tdly_q <= tdly_q - 16'h1;
                end
            end
        end
    end

    // Crossbar to sequencer input 0
    logic seq_trig;
    assign seq_trig = pwm_trigger_output;

    // Converter trigger sequencer, one chain per converter
    logic [1:0] done_s, done_d1, done_edge, chain_end, engaged;
    assign done_s = {done1_s[1], done0_s[1]};
    assign done_edge = done_s & ~done_d1;
    assign engaged = {ctrl_q[CTRL_PAIRED], 1'b1};
    mpas_seq_t seq_q [2];
    logic [1:0] cmpl_q;
    for (genvar c = 0; c < 2; c++) begin : g_seq
        assign chain_end[c] = seq_q[c] == SQ_SECOND && done_edge[c];
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                seq_q[c] <= SQ_IDLE;
                conv_start[c] <= 1'b0;
                conv_sel[c] <= 1'b0;
                done_d1[c] <= 1'b0;
                result_q[c] <= '{default: '0};
            end else begin
                done_d1[c] <= done_s[c];
                conv_start[c] <= 1'b0;
                case (seq_q[c])
                    SQ_IDLE: begin
                        if (seq_trig && engaged[c]) begin
                            seq_q[c] <= SQ_FIRST;
                            conv_start[c] <= 1'b1;
                            conv_sel[c] <= 1'b0;
                        end
                    end
                    SQ_FIRST: begin
                        if (done_edge[c]) begin
                            result_q[c][0] <= conv_data[c*CONV_BITS
                                +: CONV_BITS];
                            seq_q[c] <= SQ_SECOND;
                            conv_start[c] <= 1'b1;
                            conv_sel[c] <= 1'b1;
                        end
                    end
                    SQ_SECOND: begin
                        if (done_edge[c]) begin
                            result_q[c][1] <= conv_data[c*CONV_BITS
                                +: CONV_BITS];
                            seq_q[c] <= SQ_IDLE;
                        end
                    end
                    default: seq_q[c] <= SQ_IDLE;
                endcase
            end
        end
    end

    // Fast-loop event once every engaged chain has finished
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmpl_q <= 2'b00;
            fast_loop_irq <= 1'b0;
        end else begin
            fast_loop_irq <= 1'b0;
            if (seq_trig) begin
                cmpl_q <= 2'b00;
            end else if (((cmpl_q | chain_end) & engaged) == engaged
                && (cmpl_q | chain_end) != cmpl_q) begin
                cmpl_q <= 2'b00;
                fast_loop_irq <= ctrl_q[CTRL_FAST_IE];
            end else begin
                cmpl_q <= cmpl_q | chain_end;
            end
        end
    end

    // Quadrature decoder
    logic a_p, b_p, step_up, step_dn, fwd, rev;
    assign step_up = (enca_s[1] ^ b_p) & ~(encb_s[1] ^ a_p);
    assign step_dn = (encb_s[1] ^ a_p) & ~(enca_s[1] ^ b_p);
    assign fwd = ctrl_q[CTRL_ENC_DIR] ? step_dn : step_up;
    assign rev = ctrl_q[CTRL_ENC_DIR] ? step_up : step_dn;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            a_p <= 1'b0;
            b_p <= 1'b0;
            position_q <= 16'h0;
            revol_q <= 16'h0;
        end else begin
            a_p <= enca_s[1];
            b_p <= encb_s[1];
            if (fwd) begin
                if (position_q >= enc_mod_q) begin
                    position_q <= 16'h0;
                    revol_q <= revol_q + 16'h1;
                end else begin
                    position_q <= position_q + 16'h1;
                end
            end else if (rev) begin
                if (position_q == 16'h0) begin
                    position_q <= enc_mod_q;
                    revol_q <= revol_q - 16'h1;
                end else begin
                    position_q <= position_q - 16'h1;
                end
            end
        end
    end

    // Slow-loop timer on a divide-by-16 tick
    logic [3:0] sdiv_q;
    logic [15:0] scnt_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sdiv_q <= 4'h0;
            scnt_q <= 16'h0;
            slow_loop_irq <= 1'b0;
        end else begin
            sdiv_q <= sdiv_q + 4'h1;
            slow_loop_irq <= 1'b0;
            if (sdiv_q == 4'(SLOW_PRESC - 1)) begin
                if (scnt_q == 16'(SLOW_CMP)) begin
                    scnt_q <= 16'h0;
                    slow_loop_irq <= ctrl_q[CTRL_SLOW_IE];
                end else begin
                    scnt_q <= scnt_q + 16'h1;
                end
            end
        end
    end
endmodule

// ---- logic/mpas_pkg.sv ----
// Constants for the motor PWM and converter synchronisation block
package mpas_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MODULO = 8'h04;
    localparam logic [7:0] REG_TRIG_CMP = 8'h08;
    localparam logic [7:0] REG_DEAD_NS = 8'h0c;
    localparam logic [7:0] REG_DUTY0 = 8'h10;
    localparam logic [7:0] REG_ENC_MOD = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_POSITION = 8'h24;
    localparam logic [7:0] REG_REVOL = 8'h28;
    localparam logic [7:0] REG_CONV0 = 8'h2c;
    localparam logic [7:0] REG_CONV1 = 8'h30;
    // Control field positions
    localparam int CTRL_PWM_EN = 0;
    localparam int CTRL_PAIRED = 1;
    localparam int CTRL_ENC_DIR = 2;
    localparam int CTRL_SLOW_IE = 3;
    localparam int CTRL_FAST_IE = 4;
    localparam int CTRL_RATIO_LO = 8;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_011b;
    localparam logic [15:0] MODULO_RST = 16'h07d0;
    localparam logic [15:0] TRIG_RST = 16'h0000;
    localparam logic [15:0] DEAD_RST = 16'h01f4;
    localparam logic [15:0] ENC_MOD_RST = 16'h0fff;
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SLOW_PRESC = 16;
    localparam int SLOW_LOOP_HZ = 1000;
    localparam int SLOW_CMP_DEF = CLK_HZ / (SLOW_PRESC * SLOW_LOOP_HZ);
    localparam int CHAIN_LEN = 2;
    localparam int CONV_BITS = 12;
    // Answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_FIRST = 2'b01,
        SQ_SECOND = 2'b10
    } mpas_seq_t;
endpackage

// ---- verif/mpas_monitor.sv ----
// Assertion checker for the motor PWM block
`timescale 1ns/100ps
module mpas_monitor #(
    parameter int SLOW_CMP = 3
) (
    // Watched ports
    input wire logic core_clk,
    input wire logic rst,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_awready,
    input wire logic [2:0] pwm_top,
    input wire logic [2:0] pwm_bot,
    input wire logic fault_in,
    input wire logic [1:0] conv_start,
    input wire logic [1:0] conv_sel,
    input wire logic [1:0] conv_done,
    input wire logic pwm_trigger_output,
    input wire logic fast_loop_irq,
    input wire logic slow_loop_irq
);
    int gap_q;
    logic seen_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Cycles since the last slow tick
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_q <= 0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= slow_loop_irq ? 0 : gap_q + 1;
            seen_q <= seen_q | slow_loop_irq;
        end
    end
    property p_dead; (pwm_top & pwm_bot) == 3'h0; endproperty
    a_dead: assert property (p_dead)
        else $error("top and bottom overlap");
    property p_fault; fault_in [*4] |->
        {pwm_top, pwm_bot} == 6'h0; endproperty
    a_fault: assert property (p_fault)
        else $error("drive on during fault");
    property p_first; conv_start[0] && !conv_sel[0] |->
        $past(pwm_trigger_output); endproperty
    a_first: assert property (p_first)
        else $error("start without trigger");
    property p_second; conv_start[0] && conv_sel[0] |->
        $past(conv_done[0], 3) && !$past(conv_done[0], 4); endproperty
    a_second: assert property (p_second)
        else $error("second slot not back to back");
    property p_pair; conv_start[1] |->
        conv_start[0] && conv_sel[1] == conv_sel[0]; endproperty
    a_pair: assert property (p_pair)
        else $error("converters started apart");
    property p_fast; fast_loop_irq |-> $past(conv_done[0], 3); endproperty
    a_fast: assert property (p_fast)
        else $error("fast tick before done");
    property p_slow; slow_loop_irq && seen_q |->
        gap_q == 16 * (SLOW_CMP + 1) - 1; endproperty
    a_slow: assert property (p_slow)
        else $error("slow tick spacing");
    property p_bhold; s_axi_bvalid && !s_axi_bready |->
        !s_axi_awready ##1 s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold)
        else $error("write answer dropped");
    c_fast: cover property (fast_loop_irq);
    c_second: cover property (conv_start[0] && conv_sel[0]);
    c_fault: cover property (fault_in [*4]);
endmodule
bind mpas_top mpas_monitor #(.SLOW_CMP(SLOW_CMP)) u_mpas_monitor (
    .core_clk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_awready,
    .pwm_top, .pwm_bot, .fault_in, .conv_start, .conv_sel, .conv_done,
    .pwm_trigger_output, .fast_loop_irq, .slow_loop_irq
);

// ---- verif/mpas_conv_model.sv ----
// Converter pair model answering start pulses
`timescale 1ns/100ps
module mpas_conv_model import mpas_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Converter link
    input wire logic [1:0] conv_start,
    input wire logic [1:0] conv_sel,
    output logic [1:0] conv_done,
    output logic [2*CONV_BITS-1:0] conv_data,
    // Scenario control
    input wire logic slow,
    input wire logic [CONV_BITS-1:0] base
);
    int cnt [2];
    // Result stable around done, churning otherwise
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= '{0, 0};
            conv_done <= 2'b00;
            conv_data <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (conv_start[i]) begin
                    cnt[i] <= slow ? 14 : 5;
                end else if (cnt[i] > 0) begin
                    cnt[i] <= cnt[i] - 1;
                end
                conv_done[i] <= cnt[i] > 1 && cnt[i] < 5;
                if (cnt[i] > 1 && cnt[i] < 6) begin
                    conv_data[12*i+:12] <= base ^ {conv_sel[i], 10'h0, i[0]};
                end else begin
                    conv_data[12*i+:12] <= ~conv_data[12*i+:12];
                end
            end
        end
    end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the motor PWM block
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    import mpas_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, slow = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic fault_in = 1'b0, enc_a = 1'b0, enc_b = 1'b0, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_trigger_output;
    logic fast_loop_irq, slow_loop_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, conv_start, conv_sel, conv_done;
    logic [2:0] pwm_top, pwm_bot;
    logic [2*CONV_BITS-1:0] conv_data;
    logic [11:0] base = 12'h0;
    int n_errors = 0, n_compared = 0, n_s1 = 0, n_slow = 0;
    mpas_top #(.SLOW_CMP(3), .PWM_PRESC(1)) u_mpas_top (.core_clk, .rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pwm_top, .pwm_bot, .fault_in, .conv_start,
        .conv_sel, .conv_done, .conv_data, .enc_a, .enc_b,
        .pwm_trigger_output, .fast_loop_irq, .slow_loop_irq);
    mpas_conv_model u_mpas_conv_model (.core_clk, .rst, .conv_start,
        .conv_sel, .conv_done, .conv_data, .slow, .base);
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        n_s1 <= n_s1 + int'(conv_start[1]);
        n_slow <= n_slow + int'(slow_loop_irq);
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er = RESP_OKAY);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_bvalid);
        `CHK("bresp", er, s_axi_bresp)
        s_axi_bready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er = RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_rvalid);
        `CHK("rdata", e, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
        s_axi_rready <= 1'b0;
    endtask
    task automatic setc(input int k, input bit pr, input bit dir);
        wr(REG_CTRL, {20'h0, 4'(k), 5'h03, dir, pr, 1'b1});
    endtask
    initial begin
        int g;
        logic [5:0] seen;
        void'($urandom(32'hc5ac));
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rchk(REG_CTRL, CTRL_RST);
        rchk(REG_DEAD_NS, {16'h0, DEAD_RST});
        rchk(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'h0, RESP_SLVERR);
        wr(REG_MODULO, 32'd40);
        wr(REG_DEAD_NS, 32'd100);
        for (int i = 0; i < 3; i++) wr(REG_DUTY0 + 8'(4 * i), 8 + $urandom % 25);
        for (int k = 1; k <= 3; k++) begin
            setc(k, 1'b1, 1'b0);
            repeat (2) @(posedge core_clk iff pwm_trigger_output);
            g = 0;
            do begin
                @(posedge core_clk);
                g++;
            end while (!pwm_trigger_output);
            `CHK("period", 40 * k, g)
        end
        for (int m = 0; m < 4; m++) begin
            base <= 12'($urandom);
            slow <= m[0];
            setc(1, m[1], 1'b0);
            @(posedge core_clk iff fast_loop_irq);
            g = n_s1;
            @(posedge core_clk iff fast_loop_irq);
            rchk(REG_CONV0, {4'h0, base ^ 12'h800, 4'h0, base});
            if (m[1]) rchk(REG_CONV1, {4'h0, base ^ 12'h801, 4'h0, base ^ 12'h1});
            else `CHK("second starts", g, n_s1)
        end
        fault_in <= 1'b1;
        repeat (90) @(posedge core_clk);
        `CHK("drives in fault", 6'h0, {pwm_top, pwm_bot})
        fault_in <= 1'b0;
        seen = 6'h0;
        repeat (120) @(posedge core_clk) seen = seen | {pwm_top, pwm_bot};
        `CHK("drives back", 6'h3f, seen)
        wr(REG_ENC_MOD, 32'd3);
        for (int s = 1; s <= 7; s++) begin
            if (s == 6) setc(1, 1'b1, 1'b1);
            enc_a <= s[1] ^ s[0];
            enc_b <= s[1];
            repeat (6) @(posedge core_clk);
            if (s == 5) rchk(REG_POSITION, 32'(5 % 4));
            if (s == 5) rchk(REG_REVOL, 32'(5 / 4));
        end
        rchk(REG_POSITION, 32'd3);
        rchk(REG_REVOL, 32'd0);
        @(posedge core_clk iff slow_loop_irq);
        g = n_slow;
        repeat (640) @(posedge core_clk);
        `CHK("slow ticks", g + 10, n_slow)
        tally_and_finish();
    end
endmodule
